// ### inc/sent_cfg_pkg.sv
// Shared constants and types of the SENT output configuration block.
// Assumes a single 100 MHz system clock and a 12-bit Wishbone byte address.
package sent_cfg_pkg;

	// ----------------------------------------------------------------
	// Register map: word index, byte address is four times the index
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int IDX_W = 10;
	localparam logic [9:0] IDX_SHARED = 10'h308;
	localparam logic [9:0] IDX_DIAG_EN = 10'h309;
	localparam logic [9:0] IDX_TICK = 10'h317;
	localparam logic [9:0] IDX_OPTIONS = 10'h319;
	localparam logic [9:0] IDX_STATUS = 10'h320;

	// ----------------------------------------------------------------
	// Field positions and widths
	// ----------------------------------------------------------------
	localparam int POS_HIGHEST_ID = 16;
	localparam int HIGHEST_ID_W = 2;
	localparam int POS_DIAG_EN = 23;
	localparam int POS_TICK = 4;
	localparam int TICK_W = 7;
	localparam int POS_CRC_COVERS = 15;
	localparam int POS_IGNORE = 11;
	localparam int POS_ADDRESSING = 9;
	localparam int POS_ANGLE = 0;
	localparam int ANGLE_W = 12;
	localparam int POS_SAMPLE_TAKEN = 16;
	localparam int POS_DIAG_SEEN = 17;
	localparam int POS_SHARED = 24;
	localparam int DATA_NIBBLES = 6;

	// ----------------------------------------------------------------
	// Reset values, CRC and timing constants
	// ----------------------------------------------------------------
	localparam logic [6:0] TICK_CODE_RST = 7'h30;
	localparam logic [6:0] TICK_MIN_CODE = 7'h01;
	localparam logic [3:0] CRC_SEED = 4'h5;
	localparam logic [3:0] CRC_POLY_LOW = 4'hd;
	localparam int CLK_MHZ = 100;
	localparam int INT_CLK_MHZ = 16;
	localparam logic [6:0] CLK_MODULUS = 7'(CLK_MHZ);
	localparam logic [6:0] INT_CLK_STEP = 7'(INT_CLK_MHZ);

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] highestId;
		logic diagEn;
		logic [6:0] tickCode;
		logic addressing;
		logic ignoreSample;
		logic crcCovers;
	} cfg_t;

	typedef struct packed {
		logic sampleReq;
		logic diagPulse;
		logic stomp;
		logic addressed;
	} line_ev_t;

	typedef struct packed {
		logic valid;
		logic [3:0] statusNibble;
		logic [4*DATA_NIBBLES-1:0] data;
	} crc_req_t;

	typedef struct packed {
		logic [6:0] acc;
		logic [6:0] cnt;
		logic strobe;
	} tick_state_t;

	typedef struct packed {
		cfg_t cfg;
		logic ack;
		logic [31:0] rdData;
		logic [ANGLE_W-1:0] heldAngle;
		logic sampleTaken;
		logic diagSeen;
		logic selfTestStart;
		logic sharedLine;
		logic [3:0] crcNibble;
		logic crcValid;
	} top_state_t;

	localparam cfg_t CFG_RST = '{highestId: 2'h0, diagEn: 1'b0, tickCode: TICK_CODE_RST,
		addressing: 1'b0, ignoreSample: 1'b0, crcCovers: 1'b0};
	localparam tick_state_t TICK_STATE_RST = '{acc: 7'h00, cnt: 7'h01, strobe: 1'b0};

endpackage

// ### verilog/tick_duration_code_gen.sv
// Tick generator: derives the 16 MHz internal rate from the system clock and
// divides it by the programmed tick code. Assumes synchronous clkEn and rstN.
`timescale 1ns/1ps

module tick_duration_code_gen
	import sent_cfg_pkg::*;
(
	input wire logic clk, // System clock.
	input wire logic rstN, // Synchronised reset, active low.
	input wire logic clkEn, // Freezes all state while low.
	input wire logic [6:0] tickCode, // Programmed tick code.
	output logic tickStrobe // One cycle per completed tick.
);

	tick_state_t s_q;
	tick_state_t s_d;
	logic [6:0] accSum;
	logic intEn;
	logic [6:0] reloadVal;
	logic terminal;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// A phase accumulator gives the 16 MHz enable; its average rate is exact, the
	// single period jitters by one system clock, which the receiver tolerates.
	always_comb begin
		s_d = s_q;
		accSum = 7'(s_q.acc + INT_CLK_STEP);
		intEn = (accSum >= CLK_MODULUS);
		reloadVal = (tickCode == 7'h00) ? TICK_MIN_CODE : tickCode;
		terminal = (s_q.cnt >= reloadVal);
		s_d.acc = intEn ? 7'(accSum - CLK_MODULUS) : accSum;
		s_d.strobe = 1'b0;
		// Up-counting lets a new code take effect at once, even a smaller one.
		if (intEn) begin
			if (terminal) begin
				s_d.cnt = 7'h01;
				s_d.strobe = 1'b1;
			end else begin
				s_d.cnt = 7'(s_q.cnt + 7'h01);
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			s_q <= TICK_STATE_RST;
		end else if (clkEn) begin
			s_q <= s_d;
		end
	end

	assign tickStrobe = s_q.strobe;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_TICK_END: assert property (@(posedge clk) disable iff (!rstN)
		clkEn && intEn && terminal |=> tickStrobe && s_q.cnt == 7'h01)
		else $error("Tick did not complete at its reload count.");
	AST_TICK_MID: assert property (@(posedge clk) disable iff (!rstN)
		clkEn && intEn && !terminal |=> !tickStrobe && s_q.cnt == 7'($past(s_q.cnt) + 7'h01))
		else $error("Tick ended before its programmed length.");
	AST_TICK_ZERO: assert property (@(posedge clk) disable iff (!rstN)
		clkEn && intEn && tickCode == 7'h00 |=> tickStrobe)
		else $error("Zero code did not give a one-period tick.");
	AST_INT_RATE: assert property (@(posedge clk) disable iff (!rstN)
		clkEn && intEn |=> !intEn)
		else $error("Internal clock enable ran above its rate.");

endmodule // tick_duration_code_gen

// ### verilog/sent_output_config.sv
// SENT output configuration: Wishbone register file, tick timing, CRC scope,
// line-initiated diagnostics and sample pulse handling. Assumes the line
// decoder delivers one-cycle event pulses synchronous to clk.
`timescale 1ns/1ps

// Summary of operation
// - Tick length is the 7-bit code times one 16 MHz period.
// - Any code 0 to 127 is accepted; 127 gives 7.9375 us.
// - Code zero is forced to one internal period, same as code one.
// - CRC covers the status nibble only when the scope bit is set.
// - Line self-test start needs the line diagnostic enable bit set.
// - Without addressing any diagnostic pulse starts diagnostics when enabled.
// - With addressing a diagnostic pulse acts only if it addresses us.
// - Highest-ID field gives top sensor ID; zero means line not shared.
// - With ignore clear a sample pulse captures and holds angle data.
// - With ignore set sample pulses leave the held angle unchanged.
module sent_output_config
	import sent_cfg_pkg::*;
(
	input wire logic clk, // System clock, 100 MHz.
	input wire logic reset_n, // Asynchronous reset, active low.
	input wire logic clkEn, // Freezes all state but the reset synchroniser while low.
	input wire logic wb_cyc_i, // Wishbone cycle.
	input wire logic wb_stb_i, // Wishbone strobe.
	input wire logic wb_we_i, // Wishbone write enable.
	input wire logic [ADDR_W-1:0] wb_adr_i, // Wishbone byte address.
	input wire logic [3:0] wb_sel_i, // Wishbone byte lane selects.
	input wire logic [31:0] wb_dat_i, // Wishbone write data.
	output logic [31:0] wb_dat_o, // Wishbone read data.
	output logic wb_ack_o, // Wishbone acknowledge.
	input wire line_ev_t lineEv, // Decoded line pulses.
	input wire logic [ANGLE_W-1:0] angleIn, // Live angle from the front end.
	input wire crc_req_t crcReq, // Frame content for the CRC nibble.
	output logic [3:0] crcNibble, // Computed CRC nibble.
	output logic crcValid, // Pulse: crcNibble updated.
	output logic [ANGLE_W-1:0] heldAngle, // Sampled and held angle.
	output logic selfTestStart, // Pulse: start front-end self-test.
	output logic tickStrobe, // Pulse: one Tick_duration_code completed.
	output logic [1:0] highestId, // Highest sensor ID on the line.
	output logic sharedLine // High when the line is shared.
);

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rstMeta;
	logic rstSyncN;

	// The synchroniser runs free of clkEn so a frozen block still leaves reset.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rstMeta <= 1'b0;
			rstSyncN <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstSyncN <= rstMeta;
		end
	end

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	// Word index match for a byte address.
	function automatic logic regHit(input logic [ADDR_W-1:0] adr, input logic [IDX_W-1:0] idx);
		regHit = (adr[ADDR_W-1:2] == idx);
	endfunction

	// Byte-lane mask merge of write data into an existing word.
	function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] dat,
		input logic [3:0] sel);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		laneMerge = (old & ~m) | (dat & m);
	endfunction

	// One nibble step of the CRC-4: multiply by x^4 modulo the polynomial, add nibble.
	function automatic logic [3:0] crcStep(input logic [3:0] c, input logic [3:0] n);
		logic [3:0] r;
		r = c;
		for (int i = 0; i < 4; i++) begin
			r = r[3] ? ({r[2:0], 1'b0} ^ CRC_POLY_LOW) : {r[2:0], 1'b0};
		end
		crcStep = r ^ n;
	endfunction

	// Whole-frame CRC; the status nibble enters only when covered.
	function automatic logic [3:0] sentCrc(input logic covers, input logic [3:0] status,
		input logic [4*DATA_NIBBLES-1:0] data);
		logic [3:0] c;
		c = CRC_SEED;
		if (covers) begin
			c = crcStep(c, status);
		end
		for (int k = DATA_NIBBLES - 1; k >= 0; k--) begin
			c = crcStep(c, data[4*k +: 4]);
		end
		sentCrc = crcStep(c, 4'h0);
	endfunction

	// ----------------------------------------------------------------
	// State and tick generator
	// ----------------------------------------------------------------
	top_state_t s_q;
	top_state_t s_d;
	logic busReq;
	logic [31:0] sharedWord;
	logic [31:0] diagEnWord;
	logic [31:0] tickWord;
	logic [31:0] optionsWord;
	logic [31:0] statusWord;
	logic [31:0] wrWord;
	logic [31:0] clrMask;
	logic diagGo;
	logic sampleGo;

	tick_duration_code_gen tickGen (
		.clk(clk),
		.rstN(rstSyncN),
		.clkEn(clkEn),
		.tickCode(s_q.cfg.tickCode),
		.tickStrobe(tickStrobe)
	);

	// ----------------------------------------------------------------
	// Register words as software sees them
	// ----------------------------------------------------------------
	// Unused bits of every word read as zero.
	always_comb begin
		sharedWord = 32'h0000_0000;
		sharedWord[POS_HIGHEST_ID +: HIGHEST_ID_W] = s_q.cfg.highestId;
		diagEnWord = 32'h0000_0000;
		diagEnWord[POS_DIAG_EN] = s_q.cfg.diagEn;
		tickWord = 32'h0000_0000;
		tickWord[POS_TICK +: TICK_W] = s_q.cfg.tickCode;
		optionsWord = 32'h0000_0000;
		optionsWord[POS_CRC_COVERS] = s_q.cfg.crcCovers;
		optionsWord[POS_IGNORE] = s_q.cfg.ignoreSample;
		optionsWord[POS_ADDRESSING] = s_q.cfg.addressing;
		statusWord = 32'h0000_0000;
		statusWord[POS_ANGLE +: ANGLE_W] = s_q.heldAngle;
		statusWord[POS_SAMPLE_TAKEN] = s_q.sampleTaken;
		statusWord[POS_DIAG_SEEN] = s_q.diagSeen;
		statusWord[POS_SHARED] = s_q.sharedLine;
	end

	// ----------------------------------------------------------------
	// Line event qualification
	// ----------------------------------------------------------------
	// A stomp has no address, so the addressing option does not gate it.
	assign diagGo = s_q.cfg.diagEn &&
		((lineEv.diagPulse && (!s_q.cfg.addressing || lineEv.addressed)) || lineEv.stomp);
	assign sampleGo = lineEv.sampleReq && !s_q.cfg.ignoreSample;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// Bus access, line events and the CRC all land in one copy of the state so
	// that the sticky status bits see their set after any software clear.
	always_comb begin
		s_d = s_q;
		busReq = wb_cyc_i && wb_stb_i && !s_q.ack;
		wrWord = 32'h0000_0000;
		clrMask = 32'h0000_0000;
		s_d.ack = busReq;

		// Reads: registered data, unmapped words answer zero.
		if (busReq && !wb_we_i) begin
			if (regHit(wb_adr_i, IDX_SHARED)) begin
				s_d.rdData = sharedWord;
			end else if (regHit(wb_adr_i, IDX_DIAG_EN)) begin
				s_d.rdData = diagEnWord;
			end else if (regHit(wb_adr_i, IDX_TICK)) begin
				s_d.rdData = tickWord;
			end else if (regHit(wb_adr_i, IDX_OPTIONS)) begin
				s_d.rdData = optionsWord;
			end else if (regHit(wb_adr_i, IDX_STATUS)) begin
				s_d.rdData = statusWord;
			end else begin
				s_d.rdData = 32'h0000_0000;
			end
		end

		// Writes: byte lanes merge into the current word; unmapped writes vanish.
		if (busReq && wb_we_i) begin
			if (regHit(wb_adr_i, IDX_SHARED)) begin
				wrWord = laneMerge(sharedWord, wb_dat_i, wb_sel_i);
				s_d.cfg.highestId = wrWord[POS_HIGHEST_ID +: HIGHEST_ID_W];
			end else if (regHit(wb_adr_i, IDX_DIAG_EN)) begin
				wrWord = laneMerge(diagEnWord, wb_dat_i, wb_sel_i);
				s_d.cfg.diagEn = wrWord[POS_DIAG_EN];
			end else if (regHit(wb_adr_i, IDX_TICK)) begin
				wrWord = laneMerge(tickWord, wb_dat_i, wb_sel_i);
				s_d.cfg.tickCode = wrWord[POS_TICK +: TICK_W];
			end else if (regHit(wb_adr_i, IDX_OPTIONS)) begin
				wrWord = laneMerge(optionsWord, wb_dat_i, wb_sel_i);
				s_d.cfg.crcCovers = wrWord[POS_CRC_COVERS];
				s_d.cfg.ignoreSample = wrWord[POS_IGNORE];
				s_d.cfg.addressing = wrWord[POS_ADDRESSING];
			end else if (regHit(wb_adr_i, IDX_STATUS)) begin
				clrMask = laneMerge(32'h0000_0000, wb_dat_i, wb_sel_i);
			end
		end

		// Sticky bits clear on a written one.
		if (clrMask[POS_SAMPLE_TAKEN]) begin
			s_d.sampleTaken = 1'b0;
		end
		if (clrMask[POS_DIAG_SEEN]) begin
			s_d.diagSeen = 1'b0;
		end

		// Sample and hold; a set in the clearing cycle wins.
		if (sampleGo) begin
			s_d.heldAngle = angleIn;
			s_d.sampleTaken = 1'b1;
		end

		// Self-test start is a single pulse per accepted request.
		s_d.selfTestStart = diagGo;
		if (diagGo) begin
			s_d.diagSeen = 1'b1;
		end

		// Highest ID zero means this sensor owns the line alone.
		s_d.sharedLine = (s_d.cfg.highestId != 2'h0);

		// CRC nibble, scope chosen by software.
		s_d.crcValid = crcReq.valid;
		if (crcReq.valid) begin
			s_d.crcNibble = sentCrc(s_q.cfg.crcCovers, crcReq.statusNibble, crcReq.data);
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			s_q <= '{cfg: CFG_RST, ack: 1'b0, rdData: 32'h0000_0000, heldAngle: '0,
				sampleTaken: 1'b0, diagSeen: 1'b0, selfTestStart: 1'b0, sharedLine: 1'b0,
				crcNibble: 4'h0, crcValid: 1'b0};
		end else if (clkEn) begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Every output except tickStrobe is a field of the state register; tickStrobe comes from the tick generator's register.
	assign wb_dat_o = s_q.rdData;
	assign wb_ack_o = s_q.ack;
	assign crcNibble = s_q.crcNibble;
	assign crcValid = s_q.crcValid;
	assign heldAngle = s_q.heldAngle;
	assign selfTestStart = s_q.selfTestStart;
	assign highestId = s_q.cfg.highestId;
	assign sharedLine = s_q.sharedLine;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_SAMPLE_HOLD: assert property (@(posedge clk) disable iff (!rstSyncN)
		clkEn && lineEv.sampleReq && !s_q.cfg.ignoreSample |=> heldAngle == $past(angleIn))
		else $error("Sample pulse did not capture the angle.");
	AST_SAMPLE_IGNORE: assert property (@(posedge clk) disable iff (!rstSyncN)
		clkEn && lineEv.sampleReq && s_q.cfg.ignoreSample |=> $stable(heldAngle))
		else $error("Held angle changed while sampling was ignored.");
	AST_DIAG_BROADCAST: assert property (@(posedge clk) disable iff (!rstSyncN)
		clkEn && lineEv.diagPulse && s_q.cfg.diagEn && !s_q.cfg.addressing |=> selfTestStart)
		else $error("Broadcast diagnostic pulse was not honoured.");
	AST_DIAG_ADDRESSED: assert property (@(posedge clk) disable iff (!rstSyncN)
		clkEn && lineEv.diagPulse && s_q.cfg.addressing && !lineEv.addressed && !lineEv.stomp
		|=> !selfTestStart)
		else $error("Unaddressed diagnostic pulse started a self-test.");
	AST_DIAG_DISABLED: assert property (@(posedge clk) disable iff (!rstSyncN)
		clkEn && !s_q.cfg.diagEn |=> !selfTestStart)
		else $error("Self-test started with line diagnostics disabled.");
	AST_CRC_SCOPE: assert property (@(posedge clk) disable iff (!rstSyncN)
		clkEn && crcReq.valid |=> crcValid &&
		crcNibble == sentCrc($past(s_q.cfg.crcCovers), $past(crcReq.statusNibble), $past(crcReq.data)))
		else $error("CRC nibble does not match the selected scope.");
	AST_SHARED_LINE: assert property (@(posedge clk) disable iff (!rstSyncN)
		clkEn |=> sharedLine == (highestId != 2'h0))
		else $error("Shared line flag disagrees with the highest ID.");
	AST_WB_ACK: assert property (@(posedge clk) disable iff (!rstSyncN)
		clkEn && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("Bus request not acknowledged in one cycle.");
	AST_WB_ACK_DROP: assert property (@(posedge clk) disable iff (!rstSyncN)
		clkEn && wb_ack_o |=> !wb_ack_o)
		else $error("Acknowledge held for more than one cycle.");

endmodule // sent_output_config

// ### tb/sent_line_model.sv
// Line-side model: a SENT controller that issues decoded line pulses.
// Assumes callers invoke pulse just after a rising edge of clk.
`timescale 1ns/1ps

module sent_line_model
	import sent_cfg_pkg::*;
(
	input wire logic clk, // System clock.
	output line_ev_t lineEv // Decoded line pulses.
);
	// Event lines rest low between pulses, as the decoder delivers them.
	initial begin
		lineEv = '0;
	end

	// One event stands for exactly one cycle, then the lines go idle again.
	task automatic pulse(input line_ev_t ev);
		lineEv <= ev;
		@(posedge clk);
		lineEv <= '0;
	endtask
endmodule // sent_line_model

// ### tb/sent_output_config_bench.sv
// Self-checking bench for the SENT output configuration block.
// Assumes a 100 MHz clock and the line model driving the event pulses.
`timescale 1ns/1ps

module sent_output_config_bench;
	import sent_cfg_pkg::*;
	logic clk, reset_n, cyc, stb, we, ack, crcValid, selfTestStart, tickStrobe, sharedLine, clkEn;
	logic [ADDR_W-1:0] adr;
	logic [3:0] sel, crcNibble;
	logic [31:0] datW, datR, rd;
	logic [ANGLE_W-1:0] angleIn, heldAngle;
	logic [1:0] highestId;
	line_ev_t lineEv;
	crc_req_t crcReq;
	int nMismatch = 0;
	int checksDone = 0;
	logic [6:0] codes [5] = '{7'h00, 7'h01, 7'h02, 7'h08, 7'h7f};
	line_ev_t evs [3] = '{4'h4, 4'h5, 4'h2};

	sent_output_config uut (.clk(clk), .reset_n(reset_n), .clkEn(clkEn), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack),
		.lineEv(lineEv), .angleIn(angleIn), .crcReq(crcReq), .crcNibble(crcNibble), .crcValid(crcValid),
		.heldAngle(heldAngle), .selfTestStart(selfTestStart), .tickStrobe(tickStrobe),
		.highestId(highestId), .sharedLine(sharedLine));
	sent_line_model lineModel (.clk(clk), .lineEv(lineEv));

	// Free-running 100 MHz clock.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp) begin
			nMismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic endSim();
		$display("Comparisons %0d, mismatches %0d", checksDone, nMismatch);
		if (nMismatch == 0 && checksDone > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Classic Wishbone cycle: hold the request until ack is sampled, then idle one cycle.
	task automatic wbXfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		datW <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			check("wb ack", 32'h0, 32'h1);
			endSim();
		end
		rd = datR;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rdChk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		wbXfer(1'b0, a, 32'h0);
		check(what, rd, exp);
	endtask

	// Waits for a tick strobe; a missing strobe ends the run.
	task automatic waitTick();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (tickStrobe !== 1'b1 && n < 4000);
		if (n >= 4000) begin
			check("tick strobe", 32'h0, 32'h1);
			endSim();
		end
	endtask

	// Reference CRC: seed 5, status nibble first only when covered, trailing zero nibble.
	function automatic logic [3:0] crcRef(input logic cov, input logic [3:0] s, input logic [23:0] d);
		logic [3:0] c;
		logic [3:0] n;
		c = 4'h5;
		for (int i = 0; i < 8; i++) begin
			if (i == 0 && !cov) continue;
			n = (i == 0) ? s : (i == 7) ? 4'h0 : d[27 - 4 * i -: 4];
			for (int j = 0; j < 4; j++) c = c[3] ? ((c << 1) ^ 4'hd) : (c << 1);
			c = c ^ n;
		end
		return c;
	endfunction

	// Main sequence.
	initial begin
		int n;
		reset_n = 1'b0;
		{cyc, stb, we, adr, sel, datW, angleIn} = '0;
		crcReq = '0;
		clkEn = 1'b1;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		rdChk("highest id rst", 12'hc20, 32'h0);
		rdChk("diag enable rst", 12'hc24, 32'h0);
		rdChk("tick code rst", 12'hc5c, 32'(TICK_CODE_RST) << POS_TICK);
		rdChk("options rst", 12'hc64, 32'h0);
		rdChk("unmapped", 12'h004, 32'h0);
		$display("Reset values test done");
		// Sharing depth: every code, ending at not shared.
		for (int v = 3; v >= 0; v--) begin
			wbXfer(1'b1, 12'hc20, 32'(v) << POS_HIGHEST_ID);
			check("highestId", 32'(highestId), 32'(v));
			check("sharedLine", 32'(sharedLine), 32'(v != 0));
			rdChk("highest id reg", 12'hc20, 32'(v) << POS_HIGHEST_ID);
		end
		$display("Highest id test done");
		// Four ticks span exactly 25 cycles per internal period; short codes checked for timing only.
		for (int k = 0; k < 5; k++) begin
			wbXfer(1'b1, 12'hc5c, 32'(codes[k]) << POS_TICK);
			waitTick();
			waitTick();
			n = 0;
			for (int t = 0; t < 4; t++) begin
				do begin
					@(posedge clk);
					n++;
				end while (tickStrobe !== 1'b1 && n < 4000);
			end
			check("tick period", 32'(n), 32'(25 * ((codes[k] == 0) ? 1 : codes[k])));
			// A tick that never came has used up the bound; stop here with the mismatch counted.
			if (n >= 4000) begin
				endSim();
			end
		end
		$display("Tick period test done");
		// CRC scope off then on.
		for (int c = 0; c < 2; c++) begin
			wbXfer(1'b1, 12'hc64, 32'(c) << POS_CRC_COVERS);
			crcReq <= '{valid: 1'b1, statusNibble: 4'h9, data: 24'h3c81f6};
			@(posedge clk);
			crcReq <= '0;
			@(posedge clk);
			check("crcValid", 32'(crcValid), 32'h1);
			check("crcNibble", 32'(crcNibble), 32'(crcRef(c[0], 4'h9, 24'h3c81f6)));
		end
		$display("CRC scope test done");
		// Every enable and addressing mode against plain, addressed and stomp events.
		for (int m = 0; m < 4; m++) begin
			wbXfer(1'b1, 12'hc24, 32'(m[0]) << POS_DIAG_EN);
			wbXfer(1'b1, 12'hc64, 32'(m[1]) << POS_ADDRESSING);
			for (int e = 0; e < 3; e++) begin
				lineModel.pulse(evs[e]);
				@(posedge clk);
				check("selfTestStart", 32'(selfTestStart), 32'(m[0] && (e != 0 || !m[1])));
			end
		end
		$display("Diagnostic test done");
		// Sample pulses with ignore clear, then set.
		wbXfer(1'b1, 12'hc64, 32'h0);
		angleIn <= 12'h5a3;
		lineModel.pulse(4'h8);
		angleIn <= 12'h1c7;
		@(posedge clk);
		check("heldAngle", 32'(heldAngle), 32'h5a3);
		// A frozen block must not take a sample pulse; angleIn now differs from the held value.
		clkEn <= 1'b0;
		lineModel.pulse(4'h8);
		clkEn <= 1'b1;
		@(posedge clk);
		check("heldAngle frozen", 32'(heldAngle), 32'h5a3);
		wbXfer(1'b1, 12'hc64, 32'h1 << POS_IGNORE);
		lineModel.pulse(4'h8);
		@(posedge clk);
		check("heldAngle ignored", 32'(heldAngle), 32'h5a3);
		wbXfer(1'b0, 12'hc80, 32'h0);
		check("status angle", rd & 32'hfff, 32'h5a3);
		check("status word", rd, 32'h0003_05a3);
		// Writing ones clears both sticky bits and leaves the held angle alone.
		wbXfer(1'b1, 12'hc80, 32'h0003_0000);
		rdChk("status cleared", 12'hc80, 32'h0000_05a3);
		$display("Sample test done");
		endSim();
	end
endmodule // sent_output_config_bench
